/* logic/asram_host_ctrl.sv */
// Host controller that drives a 512K x 8 asynchronous static memory through its pins.
//
// Overview of operation
// RQ1: Memory has 512K byte locations, 19-bit address, 8-bit two-way data bus.
// RQ2: Chip select high puts memory in standby; data lines float.
// RQ3: Chip select and write enable low write the bus data into memory.
// RQ4: Memory keeps its outputs off during a write even with output enable low.
// RQ5: Chip select low, write enable high, output enable low: memory drives data.
// RQ6: Host never drives the data lines while memory is in read mode.
// RQ7: Output enable high during read keeps memory data lines floating.
// RQ8: Write lasts while chip select and write enable both low; first release ends.
// RQ9: Host times data setup and hold against the strobe edge ending the write.
// RQ10: Host keeps address stable and valid during every read or write.
// RQ11: Host presents the address no later than chip select falling.
// RQ12: With output enable low in a write, pulse exceeds release delay plus setup.
// RQ13: Host waits for memory to release the bus before driving write data.
// RQ14: Host applies nothing to the data lines while memory still drives them.
// RQ15: Strobe phases are whole cycles covering cycle, access and pulse minimums.
`timescale 1ns/1ps

module asram_host_ctrl
   import asram_pkg::*;
#(
   parameter int ADDR_BITS = 19,
   parameter int DATA_BITS = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // User request side
   input wire logic reqValid,
   input wire asram_pkg::asram_req_t reqData,
   output logic reqReady,
   output logic [asram_pkg::DATA_W-1:0] readData,
   output logic readValid,
   // Memory pins
   output asram_pkg::asram_pins_t memPins,
   input wire logic [asram_pkg::DATA_W-1:0] dataBusIn,
   output logic [asram_pkg::DATA_W-1:0] dataBusOut,
   output logic dataBusOe
);
   import asram_pkg::*;

   // The pin structs carry fixed widths, so other sizes cannot be served
   if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
      $error("asram_host_ctrl: widths must match the memory geometry");
   end
   if (WPULSE_CYC + 1 > 2 ** CNT_W || READ_CYC > 2 ** CNT_W) begin : g_bad_cnt
      $error("asram_host_ctrl: phase counter too narrow");
   end

   asram_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic outEn_reg;
   logic csN_reg;
   logic weN_reg;

   // Cycle count as a counter value
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction

   // Accept a new request only when the memory is idle
   assign reqReady = (state_reg == ASRAM_IDLE);

   // RQ15 phase sequencing
   // Read holds strobes for a full read cycle; write holds the strobe long enough
   // for the bus release plus data setup, then two recovery cycles, the first for hold.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ASRAM_IDLE;
         cnt_reg <= CNT_RST;
      end else begin
         unique case (state_reg)
            ASRAM_IDLE: begin
               if (reqValid) begin
                  state_reg <= reqData.write ? ASRAM_WRITE : ASRAM_READ;
                  cnt_reg <= reqData.write ? cyc(WPULSE_CYC) : cyc(READ_CYC);
               end
            end
            ASRAM_READ: begin
               if (cnt_reg == CNT_RST) begin
                  state_reg <= ASRAM_TURN;
                  cnt_reg <= cyc(TURN_CYC);
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            ASRAM_WRITE: begin
               if (cnt_reg == CNT_RST) begin
                  state_reg <= ASRAM_WREC;
                  cnt_reg <= cyc(WCYC_MIN > WPULSE_CYC ? WCYC_MIN - WPULSE_CYC : 1);
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            ASRAM_WREC, ASRAM_TURN: begin
               if (cnt_reg == CNT_RST) begin
                  state_reg <= ASRAM_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - CNT_W'(1);
               end
            end
            // Unused codes of the state register fall back to idle
            default: begin
               state_reg <= ASRAM_IDLE;
               cnt_reg <= CNT_RST;
            end
         endcase
      end
   end

   // RQ11 address latch
   // Address and data are captured on acceptance, on the same edge that chip select falls, and held.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_reg <= ADDR_RST;
         wdata_reg <= DATA_RST;
      end else if (reqValid && reqReady) begin
         addr_reg <= reqData.addr;
         wdata_reg <= reqData.wdata;
      end
   end

   // RQ8 strobe generation
   // Chip select and write enable fall together and write enable rises first;
   // registered so the strobes are glitch free.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         csN_reg <= 1'b1;
         weN_reg <= 1'b1;
         outEn_reg <= 1'b0;
      end else begin
         csN_reg <= !((state_reg == ASRAM_IDLE && reqValid) ||
                      (state_reg == ASRAM_READ && cnt_reg != CNT_RST) ||
                      (state_reg == ASRAM_WRITE) ||
                      (state_reg == ASRAM_WREC && cnt_reg != CNT_RST));
         // RQ12 write pulse length
         // Low for the whole write phase: release wait plus setup, never below the pulse width.
         weN_reg <= !((state_reg == ASRAM_IDLE && reqValid && reqData.write) ||
                      (state_reg == ASRAM_WRITE && cnt_reg != CNT_RST));
         // RQ13 bus release wait
         // RQ9 setup and hold
         // Data goes out once only the setup cycles remain, which is after the release delay,
         // and stays one cycle past the rising write enable. A zero hold would let the data
         // change in the same instant as the strobe, which a level-sensitive memory may
         // catch on the wrong side.
         outEn_reg <= (state_reg == ASRAM_WRITE) && (cnt_reg <= CNT_W'(SETUP_CYC));
      end
   end

   // RQ10 pins out
   // Address comes from a register loaded only at acceptance, so it cannot glitch mid-cycle.
   assign memPins.chipSel_n = csN_reg;
   assign memPins.writeEn_n = weN_reg;
   // RQ14 memory quiet first
   // Output enable stays high during writes so the memory never fights the host; the
   // trade is that a write cannot overlap the tail of a preceding read.
   assign memPins.outEn_n = !(state_reg == ASRAM_READ);
   assign memPins.wordAddress = addr_reg;
   // RQ6 host quiet in read
   assign dataBusOe = outEn_reg;
   assign dataBusOut = wdata_reg;

   // RQ5 read capture
   // Sampled on the last read cycle, after the access time has elapsed.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         readData <= DATA_RST;
         readValid <= 1'b0;
      end else begin
         readValid <= (state_reg == ASRAM_READ && cnt_reg == CNT_RST);
         if (state_reg == ASRAM_READ && cnt_reg == CNT_RST) begin
            readData <= dataBusIn;
         end
      end
   end

   // RQ6 no drive while reading
   host_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
      !memPins.outEn_n |-> !dataBusOe)
      else $error("host drives bus during read");

   // RQ2 standby idle
   standby_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
      memPins.chipSel_n |-> memPins.writeEn_n && !dataBusOe)
      else $error("strobe or drive while deselected");

   // RQ9 data held to write end
   data_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
      $rose(memPins.writeEn_n) |-> dataBusOe && $past(dataBusOe, 4) && $stable(dataBusOut))
      else $error("write data not set up or held at write end");

   // RQ10 address stable
   addr_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ10
      !$past(memPins.chipSel_n) && !memPins.chipSel_n |-> $stable(memPins.wordAddress))
      else $error("address moved while selected");

   // RQ12 pulse width
   pulse_width_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ12
      $fell(memPins.writeEn_n) |-> !memPins.writeEn_n [*7])
      else $error("write pulse too short");

   // RQ13 release wait
   release_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ13
      $fell(memPins.writeEn_n) |-> !dataBusOe [*3])
      else $error("data driven before bus release");

   // RQ8 write end order
   write_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
      $rose(memPins.writeEn_n) |-> !memPins.chipSel_n && dataBusOe)
      else $error("write not ended by write enable");

   // RQ15 read length
   read_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ15
      $fell(memPins.outEn_n) |-> !memPins.outEn_n [*8] ##1 !memPins.outEn_n ##1 readValid)
      else $error("read phase length wrong");

   // RQ11 address before select
   addr_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ11
      $fell(memPins.chipSel_n) |-> memPins.wordAddress == $past(reqData.addr))
      else $error("address not valid at select");

endmodule

/* logic/asram_pkg.sv */
// Package for the asynchronous static memory host controller: widths, timing, types.
package asram_pkg;

   // Memory geometry
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;

   // System clock period in picoseconds (200 MHz)
   localparam int CLK_PERIOD_PS = 5000;

   // Device timing figures in nanoseconds (45 ns grade)
   localparam int READ_CYCLE_NS = 45;
   localparam int ADDR_ACCESS_NS = 45;
   localparam int WRITE_CYCLE_NS = 45;
   localparam int WRITE_STROBE_PULSE_WIDTH_NS = 35;
   localparam int WRITE_STROBE_OUTPUT_RELEASE_DELAY_NS = 15;
   localparam int WRITE_DATA_SETUP_TIME_NS = 20;
   localparam int OUT_RELEASE_NS = 15;

   // Least times rounded up to whole cycles
   localparam int READ_CYC = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PULSE_MIN_CYC = (WRITE_STROBE_PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RELEASE_CYC = (WRITE_STROBE_OUTPUT_RELEASE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                / CLK_PERIOD_PS;
   localparam int SETUP_CYC = (WRITE_DATA_SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TURN_CYC = (OUT_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WCYC_MIN = (WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Write strobe low time: release wait then data setup, and at least the pulse width
   localparam int WPULSE_CYC = (RELEASE_CYC + SETUP_CYC > PULSE_MIN_CYC) ?
                               RELEASE_CYC + SETUP_CYC : PULSE_MIN_CYC;

   // Phase counter width and reset values
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // Controller phases
   typedef enum logic [2:0] {
      ASRAM_IDLE,
      ASRAM_READ,
      ASRAM_WRITE,
      ASRAM_WREC,
      ASRAM_TURN
   } asram_state_t;

   // Request from the user side
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asram_req_t;

   // Strobes and address toward the memory (active low strobes)
   typedef struct packed {
      logic chipSel_n;
      logic outEn_n;
      logic writeEn_n;
      logic [ADDR_W-1:0] wordAddress;
   } asram_pins_t;

endpackage

/* tb/asram_mem_model.sv */
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/1ps
module asram_mem_model
   import asram_pkg::*;
(
   // Strobes and address from the host
   input wire asram_pkg::asram_pins_t pins,
   // Data bus level and the memory's own drive
   input wire logic [asram_pkg::DATA_W-1:0] busLevel,
   output logic [asram_pkg::DATA_W-1:0] memData,
   output logic memOe
);
   logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] lastOut = 8'h00;
   logic writing = 1'b0;
   // drive only when selected, not writing, output enabled
   assign memOe = !pins.chipSel_n && pins.writeEn_n && !pins.outEn_n;
   // the byte on the bus when the first strobe rises is kept; committing only at
   // the end stops a strobe that falls with the address change from hitting the old address
   always @(pins or busLevel) begin
      if (!pins.chipSel_n && !pins.writeEn_n) begin
         writing = 1'b1;
      end else if (writing) begin
         writing = 1'b0;
         store[pins.wordAddress] = busLevel;
      end
   end
   // fetch the addressed byte while driving
   always @(pins or memOe) begin
      if (memOe) begin
         lastOut = store.exists(pins.wordAddress) ? store[pins.wordAddress] : 8'h00;
      end
   end
   // Released lines show the inverse of the last byte, so a stale match cannot pass
   assign memData = memOe ? lastOut : ~lastOut;
endmodule

/* tb/async_sram_512k_x8_port_test.sv */
// Self-checking testbench for the static memory host controller
`timescale 1ns/1ps
module async_sram_512k_x8_port_test;
   import asram_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   asram_req_t reqData = '0;
   logic reqReady, readValid, dataBusOe, memOe;
   logic [DATA_W-1:0] readData, dataBusOut, memData, busLevel;
   asram_pins_t memPins;
   int failures = 0;
   int checks_done = 0;
   int wLow = 0;
   int rLow = 0;

   // Clock at 200 MHz
   always #2.5 sys_clk = ~sys_clk;
   // Wire level: host drive wins, otherwise the memory model
   assign busLevel = dataBusOe ? dataBusOut : memData;

   asram_host_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqData(reqData),
      .reqReady(reqReady), .readData(readData), .readValid(readValid), .memPins(memPins),
      .dataBusIn(busLevel), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe));
   asram_mem_model partner (.pins(memPins), .busLevel(busLevel), .memData(memData), .memOe(memOe));

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic checkVal(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic checkBit(input logic got, input logic exp);
      checkVal({7'h00, got}, {7'h00, exp});
   endtask

   // Request held from a falling edge until the controller takes it
   task automatic sendReq(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(negedge sys_clk);
      reqValid = 1'b1;
      reqData = '{write: wr, addr: a, wdata: d};
      while (reqReady !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 40) begin
            failures++;
            results();
         end
      end
      @(negedge sys_clk);
      reqValid = 1'b0;
   endtask

   task automatic readCheck(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      sendReq(1'b0, a, 8'h00);
      while (readValid !== 1'b1) begin
         @(negedge sys_clk);
         n++;
         if (n > 30) begin
            failures++;
            results();
         end
      end
      checkVal(readData, exp);
   endtask

   // Bus ownership and strobe widths watched every cycle; a rising reset clears the counts
   // at once, so a write cut short by reset is never judged as a short pulse
   always @(negedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wLow = 0;
         rLow = 0;
      end else begin
         checkBit(dataBusOe & memOe, 1'b0);
         if (memPins.writeEn_n === 1'b0) begin
            wLow++;
         end else begin
            if (wLow > 0) checkBit(wLow >= PULSE_MIN_CYC, 1'b1);
            wLow = 0;
         end
         if (memPins.outEn_n === 1'b0) begin
            rLow++;
         end else begin
            if (rLow > 0) checkBit(rLow >= ACCESS_CYC, 1'b1);
            rLow = 0;
         end
      end
   end

   task automatic idleState();
      checkBit(memPins.chipSel_n, 1'b1);
      checkBit(memPins.writeEn_n & memPins.outEn_n, 1'b1);
      checkBit(dataBusOe, 1'b0);
      checkBit(reqReady, 1'b1);
   endtask

   // Boundary addresses written then read back
   task automatic edgeAddresses();
      sendReq(1'b1, 19'h00000, 8'hA5);
      sendReq(1'b1, 19'h7FFFF, 8'h3C);
      readCheck(19'h00000, 8'hA5);
      readCheck(19'h7FFFF, 8'h3C);
   endtask

   // Read then write straight after: turnaround and overwrite
   task automatic turnAround();
      readCheck(19'h00000, 8'hA5);
      sendReq(1'b1, 19'h00000, 8'h5A);
      sendReq(1'b1, 19'h2AAAA, 8'hFF);
      readCheck(19'h00000, 8'h5A);
      readCheck(19'h2AAAA, 8'hFF);
   endtask

   // Reset in mid-write drops the strobes at once; other data survives
   task automatic midReset();
      sendReq(1'b1, 19'h12345, 8'h81);
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b1;
      @(negedge sys_clk);
      idleState();
      sys_rst = 1'b0;
      readCheck(19'h7FFFF, 8'h3C);
   endtask

   initial begin
      repeat (4) @(negedge sys_clk);
      sys_rst = 1'b0;
      idleState();
      edgeAddresses();
      turnAround();
      midReset();
      repeat (20) @(negedge sys_clk);
      idleState();
      results();
   end
endmodule
